// [hw/wwdg_top.sv]
// window watchdog: 7-bit downcounter, window compare, halt handling, AXI4-Lite slave
// assumes cpu halt/wake strobes come from logic on clk_sys; wdg_reset_req feeds
// the system reset, which in turn drives rst_n of this block
`timescale 1ns/1ps
`include "wwdg_regs.svh"

module wwdg_top #(
  parameter int unsigned STEP_CYCLES = 16384
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cpu_halt,
  input wire logic ext_irq,
  input wire logic osc_irq,
  output logic [6:0] countdown,
  output logic wdg_reset_req
);

  localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

  wwdg_pkg::wwdg_state_s st;
  wwdg_pkg::wwdg_state_s next_st;

  function automatic logic reg_known(input logic [5:0] idx);
    reg_known = (idx == `WWDG_IDX_CONTROL) || (idx == `WWDG_IDX_WINDOW) ||
                (idx == `WWDG_IDX_OPTIONS);
  endfunction

  function automatic logic is_ctrl(input logic [5:0] idx);
    is_ctrl = (idx == `WWDG_IDX_CONTROL);
  endfunction

  // counting phases: run, and the single step allowed in plain halt
  function automatic logic step_allowed(input wwdg_pkg::wwdg_mode_e m, input logic done);
    step_allowed = (m == wwdg_pkg::WWDG_RUN) || ((m == wwdg_pkg::WWDG_HALT) && !done);
  endfunction

  // prescaler wraps at the step boundary
  function automatic logic [15:0] presc_next(input logic [15:0] p, input logic last);
    if (last) begin
      presc_next = 16'h0000;
    end else begin
      presc_next = p + `WWDG_ONE_16;
    end
  endfunction

  function automatic logic [6:0] count_down(input logic [6:0] c);
    count_down = c - `WWDG_ONE_7;
  endfunction

  function automatic logic [11:0] dly_down(input logic [11:0] d);
    dly_down = d - `WWDG_ONE_12;
  endfunction

  // reload is early while the counter still sits above the window limit
  function automatic logic window_breach(input logic [6:0] cnt, input logic [6:0] lim);
    window_breach = (cnt > lim);
  endfunction

  // resume delay load: count reaches zero, then one more edge
  function automatic logic [11:0] wake_delay(input logic long_sel);
    if (long_sel) begin
      wake_delay = `WWDG_DLY_LONG;
    end else begin
      wake_delay = `WWDG_DLY_SHORT;
    end
  endfunction

  // unmapped indexes answer with a slave error
  function automatic logic [1:0] resp_of(input logic [5:0] idx);
    if (reg_known(idx)) begin
      resp_of = `WWDG_RESP_OKAY;
    end else begin
      resp_of = `WWDG_RESP_SLVERR;
    end
  endfunction

  // read view of one register; unmapped indexes read as zero
  function automatic logic [31:0] reg_read(input logic [5:0] idx,
                                           input wwdg_pkg::wwdg_state_s s);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (idx)
      `WWDG_IDX_CONTROL: begin
        w[`WWDG_CTRL_ARM] = s.arm;
        w[`WWDG_CTRL_TOP:0] = s.count;
      end
      `WWDG_IDX_WINDOW: begin
        w[`WWDG_CTRL_TOP:0] = s.window;
      end
      `WWDG_IDX_OPTIONS: begin
        w[`WWDG_OPT_HW] = s.hw_sel;
        w[`WWDG_OPT_HALT_RST] = s.halt_rst;
        w[`WWDG_OPT_OSC_IE] = s.osc_ie;
        w[`WWDG_OPT_LONG_DLY] = s.long_dly;
        w[`WWDG_OPT_MODE_LO +: 2] = s.mode;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    reg_read = w;
  endfunction

  // plain register stores; the control register is handled with the counter
  function automatic wwdg_pkg::wwdg_state_s reg_store(input wwdg_pkg::wwdg_state_s s);
    wwdg_pkg::wwdg_state_s n;
    n = s;
    unique case (s.aw_idx)
      `WWDG_IDX_WINDOW: begin
        n.window = s.wdat[6:0];
      end
      `WWDG_IDX_OPTIONS: begin
        n.hw_sel = s.wdat[`WWDG_OPT_HW];
        n.halt_rst = s.wdat[`WWDG_OPT_HALT_RST];
        n.osc_ie = s.wdat[`WWDG_OPT_OSC_IE];
        n.long_dly = s.wdat[`WWDG_OPT_LONG_DLY];
      end
      default: begin
        n = s;
      end
    endcase
    reg_store = n;
  endfunction

  logic armed;
  logic tick;
  logic step_en;
  logic commit;
  logic ctrl_wr;
  logic top_after;
  logic [31:0] rd_word;
  logic [5:0] ar_idx;

  assign s_axi_awready = !st.aw_got && !st.bvalid;
  assign s_axi_wready = !st.w_got && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign countdown = st.count;
  assign wdg_reset_req = st.rst_out;
  assign ar_idx = s_axi_araddr[7:2];

  always_comb begin
    next_st = st;
    armed = st.hw_sel || st.arm;
    tick = (st.presc == STEP_LAST);
    step_en = step_allowed(st.mode, st.halt_step);
    commit = st.aw_got && st.w_got;
    ctrl_wr = commit && st.wstb && is_ctrl(st.aw_idx);
    top_after = 1'b0;
    rd_word = 32'h0000_0000;

    if (step_en) begin
      next_st.presc = presc_next(st.presc, tick);
    end

    if (step_en && tick) begin
      next_st.count = count_down(st.count);
      if (st.mode == wwdg_pkg::WWDG_HALT) begin
        next_st.halt_step = 1'b1;
      end else if (armed && (st.count == `WWDG_ROLL_FROM) && !ctrl_wr) begin
        // reload in the same cycle wins over the step
        // rollover reset
        next_st.rst_out = 1'b1;
      end
    end

    // AXI write channels, taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.aw_idx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdat = s_axi_wdata[7:0];
      next_st.wstb = s_axi_wstrb[0];
    end

    if (commit) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = resp_of(st.aw_idx);
      if (st.wstb) begin
        next_st = reg_store(next_st);
      end
    end

    if (ctrl_wr) begin
      next_st.count = st.wdat[6:0];
      next_st.arm = st.arm || st.wdat[`WWDG_CTRL_ARM];
      top_after = st.wdat[`WWDG_CTRL_TOP];
      if (armed && window_breach(st.count, st.window)) begin
        next_st.rst_out = 1'b1;
      end
      if ((st.hw_sel || next_st.arm) && !top_after) begin
        next_st.rst_out = 1'b1;
      end
    end

    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // AXI read channel
    rd_word = reg_read(ar_idx, st);
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = resp_of(ar_idx);
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end

    // power modes
    unique case (st.mode)
      wwdg_pkg::WWDG_RUN: begin
        if (cpu_halt) begin
          if (st.osc_ie) begin
            next_st.mode = wwdg_pkg::WWDG_ACTIVE_HALT;
          end else if (st.halt_rst && armed) begin
            next_st.rst_out = 1'b1;
          end else begin
            next_st.mode = wwdg_pkg::WWDG_HALT;
            next_st.halt_step = 1'b0;
          end
        end
      end
      wwdg_pkg::WWDG_HALT: begin
        if (ext_irq) begin
          next_st.mode = wwdg_pkg::WWDG_RESUME;
          next_st.dly = wake_delay(st.long_dly);
        end
      end
      wwdg_pkg::WWDG_ACTIVE_HALT: begin
        if (ext_irq || osc_irq) begin
          next_st.mode = wwdg_pkg::WWDG_RUN;
        end
      end
      wwdg_pkg::WWDG_RESUME: begin
        if (st.dly == 12'h000) begin
          next_st.mode = wwdg_pkg::WWDG_RUN;
        end else begin
          next_st.dly = dly_down(st.dly);
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st.presc <= 16'h0000;
      st.count <= `WWDG_RST_COUNT;
      st.arm <= 1'h0;
      st.window <= `WWDG_RST_WINDOW;
      st.hw_sel <= 1'h0;
      st.halt_rst <= 1'h0;
      st.osc_ie <= 1'h0;
      st.long_dly <= 1'h0;
      st.mode <= wwdg_pkg::WWDG_RESUME;
      st.halt_step <= 1'h0;
      st.dly <= `WWDG_DLY_SHORT;
      st.rst_out <= 1'h0;
      st.aw_got <= 1'h0;
      st.aw_idx <= 6'h00;
      st.w_got <= 1'h0;
      st.wdat <= 8'h00;
      st.wstb <= 1'h0;
      st.bvalid <= 1'h0;
      st.bresp <= 2'h0;
      st.rvalid <= 1'h0;
      st.rdata <= 32'h0000_0000;
      st.rresp <= 2'h0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// [hw/wwdg_regs.svh]
// register map, field positions, reset values and counts of the window watchdog
// assumes a 32-bit AXI4-Lite slave with one aligned word per register
`ifndef WWDG_REGS_SVH
`define WWDG_REGS_SVH

// printed offsets are register indexes; the byte address is four times the index
`define WWDG_IDX_CONTROL 6'h2A
`define WWDG_IDX_WINDOW 6'h30
`define WWDG_IDX_OPTIONS 6'h31

`define WWDG_CTRL_ARM 7
`define WWDG_CTRL_TOP 6
`define WWDG_OPT_HW 0
`define WWDG_OPT_HALT_RST 1
`define WWDG_OPT_OSC_IE 2
`define WWDG_OPT_LONG_DLY 3
`define WWDG_OPT_MODE_LO 8

`define WWDG_RST_COUNT 7'h7F
`define WWDG_RST_WINDOW 7'h7F
`define WWDG_ROLL_FROM 7'h40
`define WWDG_ONE_7 7'h01

`define WWDG_DLY_SHORT 12'h0FF
`define WWDG_DLY_LONG 12'hFFF
`define WWDG_ONE_12 12'h001
`define WWDG_ONE_16 16'h0001

`define WWDG_RESP_OKAY 2'h0
`define WWDG_RESP_SLVERR 2'h2

`endif

// [hw/wwdg_pkg.sv]
// types shared by the window watchdog: power mode and the whole module state
// assumes wwdg_regs.svh is compiled alongside
package wwdg_pkg;

  typedef enum logic [1:0] {
    WWDG_RUN,
    WWDG_HALT,
    WWDG_ACTIVE_HALT,
    WWDG_RESUME
  } wwdg_mode_e;

  typedef struct packed {
    logic [15:0] presc;
    logic [6:0] count;
    logic arm;
    logic [6:0] window;
    logic hw_sel;
    logic halt_rst;
    logic osc_ie;
    logic long_dly;
    wwdg_mode_e mode;
    logic halt_step;
    logic [11:0] dly;
    logic rst_out;
    logic aw_got;
    logic [5:0] aw_idx;
    logic w_got;
    logic [7:0] wdat;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } wwdg_state_s;

endpackage

// [testbench/wwdg_assertions.sv]
// checker: bus, counter and reset-request timing of the watchdog
// assumes binding onto wwdg_top, one clock domain
`timescale 1ns/1ps
module wwdg_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic cpu_halt,
  input wire logic [6:0] countdown,
  input wire logic wdg_reset_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic cause;
  assign cause = countdown == 7'h3F || countdown == 7'h40 || s_axi_bvalid || cpu_halt;
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence step;
    $changed(countdown) && !$rose(s_axi_bvalid);
  endsequence
  AST_STEP_ONE: assert property (step |-> countdown == $past(countdown) - 7'h01)
    else $error("counter moved by other than one");
  AST_STEP_GAP: assert property (step |=> (!$changed(countdown) || $rose(s_axi_bvalid)) [*8])
    else $error("counter steps too close");
  AST_WR_RESP: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  AST_RD: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_STICKY: assert property ($rose(wdg_reset_req) |=> wdg_reset_req [*8])
    else $error("reset request dropped");
  AST_CAUSE: assert property ($rose(wdg_reset_req) |-> cause || $past(cause) || $past(cause, 2))
    else $error("reset request without cause");
  AST_RST_VAL: assert property ($rose(rst_n) |-> countdown == 7'h7F && !wdg_reset_req)
    else $error("bad state after reset");
  AST_RESUME: assert property ($rose(rst_n) |=> (!$changed(countdown) || $rose(s_axi_bvalid)) [*8])
    else $error("counting before resume delay");
endmodule
bind wwdg_top wwdg_assertions i_wwdg_assertions (.*);

// [testbench/testbench.sv]
// self-checking bench of the window watchdog over AXI4-Lite
// assumes wwdg_regs.svh and wwdg_pkg compiled first
`timescale 1ns/1ps
`include "wwdg_regs.svh"
module testbench;
  logic clk_sys = 1'h0, rst_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_arvalid = 1'h0, cpu_halt = 1'h0, ext_irq = 1'h0, osc_irq = 1'h0;
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, wdg_reset_req;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [6:0] countdown, c;
  logic [65:0] q[$];
  logic [65:0] e;
  int err_total = 0, checks_done = 0, n;
  always #5 clk_sys = ~clk_sys;
  wwdg_top #(.STEP_CYCLES(16)) i_wwdg_top (.*);
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      err_total++;
      $display("MISMATCH %0t seen %h want %h", $time, s, x);
    end
  endtask
  // one bus transfer, expectation queued for the monitor
  task acc(input logic w, input logic [5:0] i, input logic [31:0] d, input logic [31:0] x,
           input logic [31:0] m, input logic [1:0] r);
    q.push_back({r, m, x});
    @(posedge clk_sys);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {i, 2'h0, i, 2'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
    do @(posedge clk_sys); while (!(w ? s_axi_awready && s_axi_wready : s_axi_arready));
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    do @(posedge clk_sys); while (!(w ? s_axi_bvalid : s_axi_rvalid));
  endtask
  task wr(input logic [5:0] i, input logic [31:0] d);
    acc(1'h1, i, d, 32'h0, 32'h0, `WWDG_RESP_OKAY);
  endtask
  task pu(input logic [2:0] v);
    @(posedge clk_sys);
    {cpu_halt, ext_irq, osc_irq} <= v;
    @(posedge clk_sys);
    {cpu_halt, ext_irq, osc_irq} <= 3'h0;
  endtask
  task nx(input string s);
    $display("test done: %s", s);
    @(posedge clk_sys);
    rst_n <= 1'h0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'h1;
  endtask
  task sy;
    c = countdown;
    do @(posedge clk_sys); while (countdown === c);
  endtask
  task wt(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    if (s_axi_bvalid || s_axi_rvalid) begin
      e = q.pop_front();
      chk({30'h0, s_axi_bvalid ? s_axi_bresp : s_axi_rresp}, {30'h0, e[65:64]});
      chk(s_axi_rdata & e[63:32], e[31:0]);
    end
  end
  initial begin
    #300000;
    err_total++;
    end_sim;
  end
  initial begin
    void'($urandom(38));
    nx("power-up");
    wt(250);
    chk(countdown, 32'h7F);
    wt(30);
    chk(countdown, 32'h7E);
    acc(1'h0, `WWDG_IDX_CONTROL, 0, 32'h0, 32'hFFFFFF80, 2'h0);
    acc(1'h0, `WWDG_IDX_WINDOW, 0, 32'h7F, 32'hFFFFFFFF, 2'h0);
    acc(1'h0, `WWDG_IDX_OPTIONS, 0, 32'h0, 32'hFFFFFFFF, 2'h0);
    acc(1'h0, 6'h00, 0, 32'h0, 32'hFFFFFFFF, `WWDG_RESP_SLVERR);
    sy;
    n = 0;
    c = countdown;
    do begin
      @(posedge clk_sys);
      n++;
    end while (countdown === c);
    chk(n, 32'h10);
    wr(`WWDG_IDX_CONTROL, 32'h41);
    wt(64);
    chk(wdg_reset_req, 32'h0);
    wr(`WWDG_IDX_CONTROL, 32'hC8);
    wr(`WWDG_IDX_CONTROL, 32'h48);
    acc(1'h0, `WWDG_IDX_CONTROL, 0, 32'h80, 32'h80, 2'h0);
    wt(160);
    chk(wdg_reset_req, 32'h1);
    nx("arm and rollover");
    wr(`WWDG_IDX_WINDOW, 32'h50);
    wr(`WWDG_IDX_CONTROL, 32'hFF);
    chk(wdg_reset_req, 32'h0);
    wr(`WWDG_IDX_CONTROL, 32'hFF);
    wt(2);
    chk(wdg_reset_req, 32'h1);
    nx("window");
    wr(`WWDG_IDX_CONTROL, {24'h0, 2'h2, 6'($urandom)});
    wt(2);
    chk(wdg_reset_req, 32'h1);
    nx("software reset");
    wr(`WWDG_IDX_OPTIONS, 32'h1);
    wr(`WWDG_IDX_CONTROL, 32'h41);
    wt(330);
    chk(wdg_reset_req, 32'h1);
    nx("hardware option");
    wt(260);
    wr(`WWDG_IDX_OPTIONS, 32'h2);
    wr(`WWDG_IDX_CONTROL, 32'hFF);
    pu(3'h4);
    wt(2);
    chk(wdg_reset_req, 32'h1);
    nx("reset on halt");
    wt(260);
    sy;
    wr(`WWDG_IDX_CONTROL, 32'hF0);
    pu(3'h4);
    wt(100);
    chk(countdown, 32'h6F);
    acc(1'h0, `WWDG_IDX_OPTIONS, 0, 32'h100, 32'h300, 2'h0);
    chk(wdg_reset_req, 32'h0);
    pu(3'h2);
    wt(200);
    chk(countdown, 32'h6F);
    wt(80);
    acc(1'h0, `WWDG_IDX_OPTIONS, 0, 32'h0, 32'h300, 2'h0);
    nx("halt");
    wt(260);
    wr(`WWDG_IDX_OPTIONS, 32'h4);
    sy;
    wr(`WWDG_IDX_CONTROL, 32'hF0);
    pu(3'h4);
    wt(100);
    chk(countdown, 32'h70);
    pu(3'h1);
    acc(1'h0, `WWDG_IDX_OPTIONS, 0, 32'h0, 32'h300, 2'h0);
    nx("active halt");
    end_sim;
  end
endmodule
